// *** verilog/hpcre_engine.v ***
`timescale 1ns/10ps
`default_nettype none
`include "hpcre_consts.vh"
// How it works
// (R1) Reports go out on their own, not as answers to commands.
// (R2) Each enabled key press or release sends type 0x80 with one byte.
// (R3) Key byte: presses 1..6, releases 7..12, order up down left right enter exit.
// (R4) Only events enabled in the host key masks are reported.
// (R5) Each selected sensor sends type 0x82 with four bytes every second.
// (R6) Temperature byte 0 is the zero-based sensor index 0..31.
// (R7) Temperature bytes 1 and 2 are raw count, low byte first.
// (R8) Temperature byte 3 is the sensor check status, zero means bad.
// (R9) Every command is answered; answer type low six bits match command.
// (R10) Normal answer type is command type ORed with 0x40.
// (R11) Ping with 0..16 bytes echoes length and data unchanged.
// (R12) Version query answers 0x41 with a 16-byte text string.
// (R13) User write needs exactly 16 bytes, stored, then empty answer.
// (R14) User read answers 0x43 with the 16 stored bytes.
// (R15) Store-boot-state pulses a save request, answered by 0x44.
// (R16) Temperature reporting and host watchdog are not saved; start disabled.
// (R17) Type 0x05 with 8,18,99 restarts the device.
// (R18) Type 0x05 with 12,28,97 resets the host via pin 3.
// (R19) Type 0x05 with 3,11,95 powers the host off via pin 2.
// (R20) Each 0x05 variant answers 0x45 with no data.
// (R21) Host keeps the reset and power pins out of user GPIO.
// (R22) A device restart repeats sensor bus discovery.
// (R23) Packet is type, length, data; length at most 18.
// (R24) A 16-bit check ends each packet, low byte first.
// (R25) Every packet is answered within 250 ms.
// (R26) Host waits for each answer and retries after timeout.
// (R27) Bad check or length is dropped; parser resynchronises.
module hpcre_engine #(
  parameter [63:0]  TEMP_CYC = `HPCRE_CLK_HZ / 1000 * `HPCRE_TEMP_PERIOD_MS,
  parameter [127:0] VER_STR  = "MODL01:h1.0,s1.0"  // Arbitrary identity text.
) (
  input  wire        i_clock,        // Module clock, 20 MHz.
  input  wire        i_rst_n,        // Asynchronous reset, active low.
  input  wire [7:0]  i_rx_data,      // Received byte.
  input  wire        i_rx_valid,     // Received byte strobe.
  input  wire        i_tx_ready,     // Transmitter takes a byte.
  input  wire [5:0]  i_key_level,    // Key levels from pins.
  input  wire [5:0]  i_press_mask,   // Press report enables.
  input  wire [5:0]  i_release_mask, // Release report enables.
  input  wire [31:0] i_temp_select,  // Sensors selected for reports.
  input  wire [15:0] i_temp_count,   // Raw count of sensor o_temp_index.
  input  wire [7:0]  i_temp_status,  // Check status of that sensor.
  output reg  [7:0]  o_tx_data,      // Byte to send.
  output reg         o_tx_valid,     // Byte valid.
  output reg  [4:0]  o_temp_index,   // Sensor being read out.
  output reg         o_store_boot,   // Save boot state pulse.
  output reg         o_self_restart, // Device restart and bus rescan pulse.
  output reg         o_host_reset,   // Host reset drive on pin 3.
  output reg         o_host_power_off, // Host power off drive on pin 2.
  output reg         o_cmd_done      // Command answered pulse.
);
  localparam S_IDLE = 4'b0001;
  localparam S_HDR  = 4'b0010;
  localparam S_DATA = 4'b0100;
  localparam S_CRC  = 4'b1000;

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer k;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `HPCRE_CRC_POLY) : (t >> 1);
      end
      crc_byte = t;
    end
  endfunction

  // Receiver.
  reg  [2:0]  rx_st;
  reg  [7:0]  rx_type;
  reg  [7:0]  rx_len;
  reg  [4:0]  rx_cnt;
  reg  [15:0] rx_crc;
  reg  [7:0]  rx_crc_lo;
  reg  [7:0]  arg [0:2];
  reg         cmd_go;
  reg  [5:0]  key_s1, key_s2, key_s3;
  reg  [5:0]  key_prev;
  reg  [5:0]  key_pend_p, key_pend_r;
  reg  [31:0] temp_pend;
  reg  [63:0] sec_cnt;
  wire        ping_we = (rx_st == 3'd2) && i_rx_valid;

  wire [7:0]  ping_rd;
  wire [7:0]  user_rd;
  reg  [4:0]  rd_addr;
  hpcre_buf #(.AW(5)) u_ping (
    .i_clock (i_clock),
    .i_we    (ping_we),
    .i_waddr (rx_cnt),
    .i_wdata (i_rx_data),
    .i_raddr (rd_addr),
    .o_rdata (ping_rd)
  );
  // User area; writes from a staging copy after the check passes.
  reg         user_we;
  reg  [4:0]  user_wa;
  hpcre_buf #(.AW(5)) u_user (
    .i_clock (i_clock),
    .i_we    (user_we),
    .i_waddr (user_wa),
    .i_wdata (ping_rd),
    .i_raddr (rd_addr),
    .o_rdata (user_rd)
  );

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st     <= 3'd0;
      rx_type   <= 8'h00;
      rx_len    <= 8'h00;
      rx_cnt    <= 5'h00;
      rx_crc    <= `HPCRE_CRC_INIT;
      rx_crc_lo <= 8'h00;
      cmd_go    <= 1'b0;
      arg[0]    <= 8'h00;
      arg[1]    <= 8'h00;
      arg[2]    <= 8'h00;
    end else begin
      cmd_go <= 1'b0;
      if (i_rx_valid) begin
        case (rx_st)
          3'd0: begin  // [R23]
            rx_type <= i_rx_data;
            rx_crc  <= crc_byte(`HPCRE_CRC_INIT, i_rx_data);
            rx_st   <= 3'd1;
          end
          3'd1: begin
            rx_len <= i_rx_data;
            rx_crc <= crc_byte(rx_crc, i_rx_data);
            rx_cnt <= 5'h00;
            if (i_rx_data > `HPCRE_MAX_LEN) begin
              rx_st <= 3'd0;  // [R27]
            end else if (i_rx_data == 8'h00) begin
              rx_st <= 3'd3;
            end else begin
              rx_st <= 3'd2;
            end
          end
          3'd2: begin
            rx_crc <= crc_byte(rx_crc, i_rx_data);
            if (rx_cnt < 5'd3) begin
              arg[rx_cnt[1:0]] <= i_rx_data;
            end
            rx_cnt <= rx_cnt + 5'd1;
            if ({3'b000, rx_cnt} == rx_len - 8'h01) begin
              rx_st <= 3'd3;
            end
          end
          3'd3: begin
            rx_crc_lo <= i_rx_data;  // [R24]
            rx_st     <= 3'd4;
          end
          3'd4: begin
            rx_st  <= 3'd0;
            cmd_go <= ({i_rx_data, rx_crc_lo} == ~rx_crc);  // [R27]
          end
          default: rx_st <= 3'd0;
        endcase
      end
    end
  end

  // Key edges through a three-stage synchroniser.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_s1   <= 6'h00;
      key_s2   <= 6'h00;
      key_s3   <= 6'h00;
      key_prev <= 6'h00;
    end else begin
      key_s1 <= i_key_level;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
      key_prev <= (key_s2 & key_s3) | (key_prev & (key_s2 | key_s3));
    end
  end
  wire [5:0] key_now = (key_s2 & key_s3) | (key_prev & (key_s2 | key_s3));
  wire [5:0] ev_p = key_now & ~key_prev & i_press_mask;    // [R4]
  wire [5:0] ev_r = ~key_now & key_prev & i_release_mask;  // [R4]

  // Transmitter.
  reg  [3:0]  tx_st;
  reg  [7:0]  tx_type;
  reg  [7:0]  tx_len;
  reg  [4:0]  tx_cnt;
  reg  [15:0] tx_crc;
  reg  [1:0]  src;      // 0 ping, 1 user, 2 version, 3 report
  reg  [7:0]  rpt [0:3];
  reg         cmd_pend;
  reg  [7:0]  c_type;
  reg  [7:0]  c_len;
  reg  [1:0]  c_src;
  reg  [1:0]  c_act;
  reg  [7:0]  ucopy;
  reg         gap;
  reg  [4:0]  sel_t;
  reg  [2:0]  sel_k;
  reg         k_rel;
  reg         k_hit;
  reg         t_hit;
  reg  [15:0] pulse_cnt;
  integer     n;

  always @* begin
    sel_t = 5'd0;
    t_hit = 1'b0;
    for (n = 31; n >= 0; n = n - 1) begin
      if (temp_pend[n]) begin
        sel_t = n[4:0];
        t_hit = 1'b1;
      end
    end
    sel_k = 3'd0;
    k_rel = 1'b0;
    k_hit = 1'b0;
    for (n = 5; n >= 0; n = n - 1) begin
      if (key_pend_r[n]) begin
        sel_k = n[2:0];
        k_rel = 1'b1;
        k_hit = 1'b1;
      end
    end
    for (n = 5; n >= 0; n = n - 1) begin
      if (key_pend_p[n]) begin
        sel_k = n[2:0];
        k_rel = 1'b0;
        k_hit = 1'b1;
      end
    end
  end

  wire a_ok = (arg[0] == `HPCRE_REBOOT_A0) && (arg[1] == `HPCRE_REBOOT_A1)
              && (arg[2] == `HPCRE_REBOOT_A2);
  wire b_ok = (arg[0] == `HPCRE_HRST_A0) && (arg[1] == `HPCRE_HRST_A1)
              && (arg[2] == `HPCRE_HRST_A2);
  wire c_ok = (arg[0] == `HPCRE_HOFF_A0) && (arg[1] == `HPCRE_HOFF_A1)
              && (arg[2] == `HPCRE_HOFF_A2);
  wire [7:0] ver_byte = VER_STR[8'd127 - {tx_cnt[3:0], 3'b000} -: 8];
  wire       sec_tick = (sec_cnt >= TEMP_CYC - 64'd1);

  // Next data byte from whichever source this packet reads.
  always @* begin
    case (src)
      2'd0: ucopy = ping_rd;
      2'd1: ucopy = user_rd;
      2'd2: ucopy = ver_byte;
      default: ucopy = rpt[tx_cnt[1:0]];
    endcase
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st <= 4'b0001; tx_type <= 8'h00; tx_len <= 8'h00;
      tx_cnt <= 5'h00; tx_crc <= `HPCRE_CRC_INIT; src <= 2'd0;
      rpt[0] <= 8'h00; rpt[1] <= 8'h00; rpt[2] <= 8'h00; rpt[3] <= 8'h00;
      cmd_pend <= 1'b0; c_type <= 8'h00; c_len <= 8'h00;
      c_src <= 2'd0; c_act <= 2'd0;
      key_pend_p <= 6'h00; key_pend_r <= 6'h00;
      temp_pend <= 32'h0; sec_cnt <= 64'h0;
      o_tx_data <= 8'h00; o_tx_valid <= 1'b0; o_temp_index <= 5'h00;
      o_store_boot <= 1'b0; o_self_restart <= 1'b0;
      o_host_reset <= 1'b0; o_host_power_off <= 1'b0; o_cmd_done <= 1'b0;
      rd_addr <= 5'h00; user_we <= 1'b0; user_wa <= 5'h00;
      pulse_cnt <= 16'h0; gap <= 1'b0;
    end else begin
      o_store_boot <= 1'b0;
      o_self_restart <= 1'b0;
      o_cmd_done <= 1'b0;
      user_we <= 1'b0;
      // Pending events; a new event wins over the clear below.
      key_pend_p <= key_pend_p | ev_p;  // [R1]
      key_pend_r <= key_pend_r | ev_r;
      if (sec_tick) begin
        sec_cnt   <= 64'h0;
        temp_pend <= i_temp_select;  // [R5] [R16]
      end else begin
        sec_cnt <= sec_cnt + 64'd1;
      end
      if (pulse_cnt != 16'h0) begin
        pulse_cnt <= pulse_cnt - 16'h1;
      end else begin
        o_host_reset <= 1'b0;
      end
      // Decode a checked command.  [R9]
      if (cmd_go) begin
        cmd_pend <= 1'b1;
        c_type <= rx_type | `HPCRE_RESP_BIT;  // [R10]
        c_len <= 8'h00; c_src <= 2'd0; c_act <= 2'd0;
        case (rx_type)
          `HPCRE_T_PING: if (rx_len <= `HPCRE_PING_MAX) begin
            c_len <= rx_len;  // [R11]
          end else c_type <= rx_type | `HPCRE_ERR_BITS;
          `HPCRE_T_VERSION: if (rx_len == 8'h00) begin
            c_len <= `HPCRE_VER_LEN; c_src <= 2'd2;  // [R12]
          end else c_type <= rx_type | `HPCRE_ERR_BITS;
          `HPCRE_T_UWRITE: if (rx_len == `HPCRE_USER_LEN) begin
            c_act <= 2'd1;  // [R13]
          end else c_type <= rx_type | `HPCRE_ERR_BITS;
          `HPCRE_T_UREAD: if (rx_len == 8'h00) begin
            c_len <= `HPCRE_USER_LEN; c_src <= 2'd1;  // [R14]
          end else c_type <= rx_type | `HPCRE_ERR_BITS;
          `HPCRE_T_STORE: if (rx_len == 8'h00) begin
            o_store_boot <= 1'b1;  // [R15]
          end else c_type <= rx_type | `HPCRE_ERR_BITS;
          `HPCRE_T_REBOOT: if (rx_len == 8'h03 && (a_ok | b_ok | c_ok)) begin
            c_act <= a_ok ? 2'd2 : (b_ok ? 2'd3 : 2'd0);  // [R20]
            if (c_ok) o_host_power_off <= 1'b1;  // [R19]
          end else c_type <= rx_type | `HPCRE_ERR_BITS;
          default: c_type <= rx_type | `HPCRE_ERR_BITS;
        endcase
      end
      case (tx_st)
        S_IDLE: begin
          if (cmd_pend && c_act == 2'd1 && tx_cnt != 5'd17) begin
            // Copy staged user bytes into the nonvolatile area.
            rd_addr <= tx_cnt; user_wa <= tx_cnt - 5'd1;
            user_we <= (tx_cnt != 5'd0);
            tx_cnt <= tx_cnt + 5'd1;
          end else if (cmd_pend) begin  // [R25]
            cmd_pend <= 1'b0;
            tx_type <= c_type; tx_len <= c_len; src <= c_src;
            tx_st <= 4'b0010; tx_cnt <= 5'h00;
            if (c_act == 2'd3) begin
              o_host_reset <= 1'b1;  // [R18]
              pulse_cnt <= `HPCRE_PULSE_CYC;
            end
          end else if (k_hit) begin
            tx_type <= `HPCRE_T_KEYRPT; tx_len <= `HPCRE_KEY_LEN;  // [R2]
            rpt[0] <= {5'b0, sel_k} + (k_rel ? 8'd7 : 8'd1);  // [R3]
            if (k_rel) key_pend_r[sel_k] <= ev_r[sel_k];
            else key_pend_p[sel_k] <= ev_p[sel_k];
            src <= 2'd3; tx_st <= 4'b0010; tx_cnt <= 5'h00;
          end else if (t_hit) begin
            o_temp_index <= sel_t;
            // Sensor data belong to the index shown one cycle earlier.
            if (o_temp_index == sel_t) begin
              tx_type <= `HPCRE_T_TEMPRPT; tx_len <= `HPCRE_TEMP_LEN;
              rpt[0] <= {3'b000, sel_t};               // [R6]
              rpt[1] <= i_temp_count[7:0];             // [R7]
              rpt[2] <= i_temp_count[15:8];            // [R7]
              rpt[3] <= i_temp_status;                 // [R8]
              // A re-arm in the same cycle wins over this clear.
              temp_pend[sel_t] <= sec_tick & i_temp_select[sel_t];
              src <= 2'd3; tx_st <= 4'b0010; tx_cnt <= 5'h00;
            end
          end else begin
            tx_cnt <= 5'h00;
          end
        end
        S_HDR: begin  // Type then length.
          if (!o_tx_valid || i_tx_ready) begin
            o_tx_valid <= 1'b1;
            if (tx_cnt == 5'd0) begin
              o_tx_data <= tx_type;
              tx_crc <= crc_byte(`HPCRE_CRC_INIT, tx_type);
              tx_cnt <= 5'd1;
              rd_addr <= 5'd0;
            end else begin
              o_tx_data <= tx_len;
              tx_crc <= crc_byte(tx_crc, tx_len);
              tx_cnt <= 5'd0;
              tx_st <= (tx_len == 8'h00) ? 4'b1000 : 4'b0100;
            end
          end
        end
        S_DATA: begin  // Data bytes; memories read one cycle ahead.
          if (gap) begin
            // A memory byte leaves one slot for the next registered read.
            gap <= 1'b0;
            if (i_tx_ready) begin
              o_tx_valid <= 1'b0;
            end
          end else if (!o_tx_valid || i_tx_ready) begin
            o_tx_valid <= 1'b1;
            o_tx_data <= ucopy;
            tx_crc <= crc_byte(tx_crc, ucopy);
            rd_addr <= tx_cnt + 5'd1;
            tx_cnt <= tx_cnt + 5'd1;
            gap <= ~src[1];
            if ({3'b000, tx_cnt} == tx_len - 8'h01) begin
              tx_st <= 4'b1000;
              tx_cnt <= 5'd0;
              gap <= 1'b0;
            end
          end
        end
        S_CRC: begin  // Check value, low byte first.  [R24]
          if (!o_tx_valid || i_tx_ready) begin
            o_tx_valid <= 1'b1;
            if (tx_cnt == 5'd0) begin
              o_tx_data <= ~tx_crc[7:0];
              tx_cnt <= 5'd1;
            end else if (tx_cnt == 5'd1) begin
              o_tx_data <= ~tx_crc[15:8];
              tx_cnt <= 5'd2;
            end else begin
              o_tx_valid <= 1'b0;
              tx_cnt <= 5'd0;
              tx_st <= 4'b0001;
              if (src != 2'd3) begin
                o_cmd_done <= 1'b1;
                // Restart and bus rescan follow the answer.  [R17] [R22]
                o_self_restart <= (c_act == 2'd2) & (tx_type == 8'h45);
              end
            end
          end
        end
        default: tx_st <= 4'b0001;
      endcase
      if (rx_st == 3'd0 && i_rx_valid) c_act <= (cmd_pend ? c_act : 2'd0);
    end
  end
endmodule // hpcre_engine
`default_nettype wire

// *** verilog/hpcre_consts.vh ***
`ifndef HPCRE_CONSTS_VH
`define HPCRE_CONSTS_VH
`define HPCRE_T_PING        8'h00
`define HPCRE_T_VERSION     8'h01
`define HPCRE_T_UWRITE      8'h02
`define HPCRE_T_UREAD       8'h03
`define HPCRE_T_STORE       8'h04
`define HPCRE_T_REBOOT      8'h05
`define HPCRE_T_KEYRPT      8'h80
`define HPCRE_T_TEMPRPT     8'h82
`define HPCRE_RESP_BIT      8'h40
`define HPCRE_ERR_BITS      8'hC0
`define HPCRE_MAX_LEN       8'h12
`define HPCRE_PING_MAX      8'h10
`define HPCRE_USER_LEN      8'h10
`define HPCRE_VER_LEN       8'h10
`define HPCRE_TEMP_LEN      8'h04
`define HPCRE_KEY_LEN       8'h01
`define HPCRE_CRC_INIT      16'hFFFF
`define HPCRE_CRC_POLY      16'h8408
`define HPCRE_REBOOT_A0     8'h08
`define HPCRE_REBOOT_A1     8'h12
`define HPCRE_REBOOT_A2     8'h63
`define HPCRE_HRST_A0       8'h0C
`define HPCRE_HRST_A1       8'h1C
`define HPCRE_HRST_A2       8'h61
`define HPCRE_HOFF_A0       8'h03
`define HPCRE_HOFF_A1       8'h0B
`define HPCRE_HOFF_A2       8'h5F
`define HPCRE_CLK_HZ        20000000
`define HPCRE_TEMP_PERIOD_MS 1000
`define HPCRE_ANSWER_MS     250
`define HPCRE_PULSE_CYC     16'h0400
`endif

// *** verilog/hpcre_buf.v ***
`timescale 1ns/10ps
`default_nettype none
// Small byte memory with registered read data.
module hpcre_buf #(
  parameter AW = 5
) (
  input  wire          i_clock,  // Module clock.
  input  wire          i_we,     // Write strobe.
  input  wire [AW-1:0] i_waddr,  // Write address.
  input  wire [7:0]    i_wdata,  // Write data.
  input  wire [AW-1:0] i_raddr,  // Read address.
  output reg  [7:0]    o_rdata   // Registered read data.
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // hpcre_buf
`default_nettype wire

// *** tb/hpcre_engine_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module hpcre_engine_sva (
  input wire logic       i_clock,          // Module clock.
  input wire logic       i_rst_n,          // Reset, active low.
  input wire logic       i_tx_ready,       // Host takes a byte.
  input wire logic [7:0] o_tx_data,        // Byte to send.
  input wire logic       o_tx_valid,       // Byte valid.
  input wire logic       o_store_boot,     // Save pulse.
  input wire logic       o_self_restart,   // Restart pulse.
  input wire logic       o_host_reset,     // Host reset drive.
  input wire logic       o_host_power_off, // Host power off drive.
  input wire logic       o_cmd_done        // Answer done pulse.
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  logic [15:0] hr_cnt;
  // Counts how long the host reset drive has stood high.
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n)
      hr_cnt <= 16'h0000;
    else
      hr_cnt <= o_host_reset ? hr_cnt + 16'h0001 : 16'h0000;
  end
  sequence s_stall;
    o_tx_valid && !i_tx_ready;
  endsequence
  sequence s_done_soon;
    ##[0:300] o_cmd_done;
  endsequence
  a_tx_hold: assert property (s_stall |=> o_tx_valid && $stable(o_tx_data))
    else $error("Byte changed before the host took it");
  a_store_pulse: assert property (o_store_boot |=> !o_store_boot)
    else $error("Save pulse longer than one cycle");
  a_store_answered: assert property (o_store_boot |-> s_done_soon)
    else $error("Save request not answered");
  a_restart_pulse: assert property (o_self_restart |=> !o_self_restart)
    else $error("Restart pulse longer than one cycle");
  a_done_pulse: assert property (o_cmd_done |=> !o_cmd_done)
    else $error("Done pulse longer than one cycle");
  a_power_latch: assert property (o_host_power_off |=> o_host_power_off)
    else $error("Host power off dropped");
  a_hreset_min: assert property ($rose(o_host_reset) |-> o_host_reset [*8])
    else $error("Host reset pulse too short");
  a_hreset_bound: assert property (hr_cnt <= 16'd1100)
    else $error("Host reset pulse too long");
  a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_tx_valid && !o_host_reset)
    else $error("Output active right after reset");
endmodule // hpcre_engine_sva
bind hpcre_engine hpcre_engine_sva u_sva (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
  .o_store_boot(o_store_boot), .o_self_restart(o_self_restart),
  .o_host_reset(o_host_reset), .o_host_power_off(o_host_power_off),
  .o_cmd_done(o_cmd_done));
`default_nettype wire

// *** tb/hpcre_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host side: sends whole packets and collects every byte the device sends.
// It never claims the reset or power pins for user GPIO.
module hpcre_host_model (
  input  wire logic       i_clock,    // Module clock.
  input  wire logic       i_slow,     // Stall every other byte slot.
  input  wire logic [7:0] i_tx_data,  // Byte from the device.
  input  wire logic       i_tx_valid, // Byte valid from the device.
  output logic      [7:0] o_rx_data,  // Byte to the device.
  output logic            o_rx_valid, // Byte strobe to the device.
  output logic            o_tx_ready  // Host takes a byte.
);
  logic [7:0] rxq[$];
  initial begin
    o_rx_data = 8'h00;
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b1;
  end
  function automatic [15:0] crc_upd(input [15:0] c, input [7:0] d);
    integer i;
    begin
      crc_upd = c ^ {8'h00, d};
      for (i = 0; i < 8; i++)
        crc_upd = crc_upd[0] ? (crc_upd >> 1) ^ 16'h8408 : crc_upd >> 1;
    end
  endfunction
  // Idle line shows the inverted byte so a late sample cannot match.
  task automatic put(input [7:0] b);
    begin
      @(negedge i_clock);
      o_rx_data = b;
      o_rx_valid = 1'b1;
      @(negedge i_clock);
      o_rx_valid = 1'b0;
      o_rx_data = ~b;
    end
  endtask
  task automatic send(input [7:0] t, input [7:0] n, input [151:0] d,
                      input bit bad);
    logic [15:0] c;
    integer i;
    begin
      c = crc_upd(16'hFFFF, t);
      c = crc_upd(c, n);
      put(t);
      put(n);
      for (i = 0; i < n; i++) begin
        c = crc_upd(c, d[8*i +: 8]);
        put(d[8*i +: 8]);
      end
      c = ~c ^ {15'h0000, bad};
      put(c[7:0]);
      put(c[15:8]);
    end
  endtask
  always @(negedge i_clock)
    o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
  always @(posedge i_clock)
    if (i_tx_valid && o_tx_ready)
      rxq.push_back(i_tx_data);
endmodule // hpcre_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam [127:0] VER = "TBVER1:h2.0,s3.0"; // Arbitrary identity text.
  logic        clock, rst_n, rx_valid, tx_ready, tx_valid, slow;
  logic        store_boot, self_restart, host_reset, host_power_off, cmd_done;
  logic [7:0]  rx_data, tx_data, temp_status;
  logic [5:0]  key_level, press_mask, release_mask;
  logic [31:0] temp_select;
  logic [15:0] temp_count;
  logic [4:0]  temp_index;
  logic [151:0] v, w;
  integer      err_total, tests_run, restarts, stores, i;
  hpcre_engine #(.TEMP_CYC(64'd200), .VER_STR(VER)) DUT (
    .i_clock(clock), .i_rst_n(rst_n), .i_rx_data(rx_data),
    .i_rx_valid(rx_valid), .i_tx_ready(tx_ready), .i_key_level(key_level),
    .i_press_mask(press_mask), .i_release_mask(release_mask),
    .i_temp_select(temp_select), .i_temp_count(temp_count),
    .i_temp_status(temp_status), .o_tx_data(tx_data), .o_tx_valid(tx_valid),
    .o_temp_index(temp_index), .o_store_boot(store_boot),
    .o_self_restart(self_restart), .o_host_reset(host_reset),
    .o_host_power_off(host_power_off), .o_cmd_done(cmd_done));
  hpcre_host_model u_host (.i_clock(clock), .i_slow(slow),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    if (self_restart === 1'b1)
      restarts++;
    if (store_boot === 1'b1)
      stores++;
  end
  // Sensor 31 reads 0x1234, every other sensor reads zero.
  always @(negedge clock)
    temp_count <= (temp_index == 5'h1F) ? 16'h1234 : 16'h0000;
  task automatic wrap_up;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task automatic chk8(input [7:0] got, input [7:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        err_total++;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic pop(output [7:0] b);
    integer k;
    begin
      for (k = 0; k < 3000 && u_host.rxq.size() == 0; k++)
        @(negedge clock);
      b = 8'hXX;
      if (u_host.rxq.size() != 0)
        b = u_host.rxq.pop_front();
    end
  endtask
  task automatic expect_pkt(input [7:0] t, input [7:0] n, input [151:0] d);
    logic [15:0] c;
    logic [7:0] b;
    integer k;
    begin
      pop(b);
      chk8(b, t);
      c = u_host.crc_upd(16'hFFFF, b);
      pop(b);
      chk8(b, n);
      c = u_host.crc_upd(c, b);
      for (k = 0; k < n; k++) begin
        pop(b);
        chk8(b, d[8*k +: 8]);
        c = u_host.crc_upd(c, b);
      end
      pop(b);
      chk8(b, ~c[7:0]);
      pop(b);
      chk8(b, ~c[15:8]);
    end
  endtask
  // The host waits for each answer before the next command.
  task automatic cmd(input [7:0] t, input [7:0] n, input [151:0] d,
                     input [7:0] et, input [7:0] en, input [151:0] ed);
    begin
      u_host.send(t, n, d, 1'b0);
      expect_pkt(et, en, ed);
    end
  endtask
  task automatic quiet(input string s);
    begin
      repeat (300) @(negedge clock);
      chk8(u_host.rxq.size(), 8'h00);
      $display("Test %s done", s);
    end
  endtask
  initial begin
    err_total = 0;
    tests_run = 0;
    restarts = 0;
    stores = 0;
    rst_n = 1'b0;
    slow = 1'b1;
    key_level = 6'h00;
    press_mask = 6'h00;
    release_mask = 6'h00;
    temp_select = 32'h0000_0000;
    temp_status = 8'h00;
    repeat (12) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    for (i = 0; i < 19; i++)
      v[8*i +: 8] = 8'h0F * i[7:0] + 8'h01;
    cmd(8'h00, 8'h00, v, 8'h40, 8'h00, v);
    cmd(8'h00, 8'h10, v, 8'h40, 8'h10, v);
    cmd(8'h00, 8'h11, v, 8'hC0, 8'h00, v);
    for (i = 0; i < 16; i++)
      w[8*i +: 8] = VER[127-8*i -: 8];
    cmd(8'h01, 8'h00, v, 8'h41, 8'h10, w);
    cmd(8'h01, 8'h01, v, 8'hC1, 8'h00, v);
    quiet("ping and version");
    w = ~v;
    cmd(8'h02, 8'h10, w, 8'h42, 8'h00, v);
    u_host.send(8'h02, 8'h10, v, 1'b1);
    quiet("corrupt write dropped");
    cmd(8'h03, 8'h00, v, 8'h43, 8'h10, w);
    cmd(8'h04, 8'h00, v, 8'h44, 8'h00, v);
    chk8(stores, 8'h01);
    cmd(8'h05, 8'h03, 24'h621208, 8'hC5, 8'h00, v);
    cmd(8'h05, 8'h03, 24'h631208, 8'h45, 8'h00, v);
    repeat (2) @(negedge clock);
    chk8(restarts, 8'h01);
    cmd(8'h05, 8'h03, 24'h611C0C, 8'h45, 8'h00, v);
    chk8({7'h00, host_reset}, 8'h01);
    cmd(8'h05, 8'h03, 24'h5F0B03, 8'h45, 8'h00, v);
    chk8({7'h00, host_power_off}, 8'h01);
    quiet("commands");
    slow = 1'b0;
    @(negedge clock);
    cmd(8'h00, 8'h10, v, 8'h40, 8'h10, v);
    cmd(8'h03, 8'h00, v, 8'h43, 8'h10, w);
    press_mask = 6'h04;
    release_mask = 6'h20;
    key_level = 6'h24;
    expect_pkt(8'h80, 8'h01, 8'h03);
    @(negedge clock) key_level = 6'h00;
    expect_pkt(8'h80, 8'h01, 8'h0C);
    quiet("keys");
    @(negedge clock);
    temp_select = 32'h8000_0000;
    expect_pkt(8'h82, 8'h04, 32'h0012_341F);
    chk8({3'h0, temp_index}, 8'h1F);
    @(negedge clock) temp_status = 8'h5A;
    expect_pkt(8'h82, 8'h04, 32'h5A12_341F);
    @(negedge clock) temp_select = 32'h0000_0000;
    repeat (300) @(negedge clock);
    u_host.rxq.delete();
    quiet("temperature");
    wrap_up;
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
